// ### gpp_pkg.sv
// Package for the five-pin general-purpose port: offsets, fields, reset values, structs
package gpp_pkg;

  localparam int GPP_PINS   = 5;
  localparam int GPP_AW     = 2;
  localparam int GPP_DW     = 8;

  // Register offsets on the plain register port
  localparam logic [GPP_AW-1:0] GPP_OFS_LEVEL = 2'h0;
  localparam logic [GPP_AW-1:0] GPP_OFS_LATCH = 2'h1;
  localparam logic [GPP_AW-1:0] GPP_OFS_DIR   = 2'h2;

  // Field positions
  localparam int GPP_BIT_PU_D  = 7;
  localparam int GPP_BIT_PU_E  = 6;
  localparam int GPP_BIT_PU_J  = 5;
  localparam int GPP_BIT_SER2  = 7;
  localparam int GPP_BIT_SER1  = 6;
  localparam int GPP_BIT_SPI   = 7;
  localparam int GPP_BIT_CC2   = 6;
  localparam int GPP_BIT_CC1   = 5;
  localparam int GPP_PIN_BIAS  = 0;
  localparam int GPP_PIN_TX    = 1;
  localparam int GPP_PIN_DT    = 2;
  localparam int GPP_PIN_CAPB  = 3;
  localparam int GPP_PIN_SEG   = 4;

  // Reset values: pull-ups disabled, pins inputs, latch clear
  localparam logic [2:0]          GPP_RST_PU    = 3'h7;
  localparam logic [GPP_PINS-1:0] GPP_RST_DIR   = 5'h1F;
  localparam logic [GPP_PINS-1:0] GPP_RST_LAT   = 5'h00;
  localparam logic [2:0]          GPP_RST_PODS  = 3'h0;
  localparam logic [1:0]          GPP_RST_SODS  = 2'h0;
  localparam logic [GPP_DW-1:0]   GPP_ZERO_BYTE = 8'h00;

  // Peripheral requests that steer the pins
  typedef struct packed {
    logic ser2_active;
    logic ser2_tx_en;
    logic ser2_tx;
    logic ser2_dt_en;
    logic ser2_dt;
    logic lcd_segment_26_drive_en;
    logic lcd_segment_26_drive;
    logic rtc_en;
    logic rtc;
    logic lcd_pump_en;
    logic lcd_bias_en;
  } gpp_periph_s;

  // Open-drain selects handed to the peripherals
  typedef struct packed {
    logic serial2_open_drain_sel;
    logic serial1_open_drain_sel;
    logic spi_open_drain_sel;
    logic capcomp2_open_drain_sel;
    logic capcomp1_open_drain_sel;
  } gpp_od_s;

endpackage

// ### gpp_sync.sv
// Two-flop synchroniser bank for the pin inputs
`timescale 1ns/1ps
module gpp_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end
        else if (ce)
        begin
          meta_ff[i] <= d[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign q = sync_ff;
endmodule // gpp_sync

// ### gpp_port.sv
// Five-pin general-purpose port with pull-up and open-drain control bits
//
// How it works
// R1: Five pins, 0 to 4, each usable as input or output.
// R2: Direction 0 drives latch onto pin; 1 makes pin an input.
// R3: Latch bit 7 makes pin 1 serial output open-drain while serial 2 active.
// R4: Enabled LCD segment 26 overrides everything on pin 4.
// R5: Charge-pump or bias use removes all other functions on pins 2, 3, 0.
// R6: Peripheral direction overrides never alter the stored direction bits.
// R7: Data register bits 7..5 low enable pull-ups of ports D, E, J.
// R8: Any reset disables all pull-ups.
// R9: Direction bits 7..5 and latch bits 7..6 select peripheral open-drain.
// R10: Latch bit 5 is unimplemented and reads zero.
// R11: Small package: port J pull-up bit unimplemented, reads zero.
// R12: Serial 2 transmit or sync data output beats the port latch.
// R13: Software sets pin 2 direction to input before sync data receive.
// R14: Pin 4 carries real-time clock output regardless of direction.
// R15: Data register low bits read pins; writes load the output latch.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter bit HAS_PORT_J = 1'b1
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic [GPP_AW-1:0]     ADDR,
  input  wire logic [GPP_DW-1:0]     WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [GPP_DW-1:0]     RDATA,
  input  wire gpp_pkg::gpp_periph_s  PERIPH,
  input  wire logic [GPP_PINS-1:0]   PIN_I,
  output logic      [GPP_PINS-1:0]   PIN_O,
  output logic      [GPP_PINS-1:0]   PIN_OE_N,
  output logic      [GPP_PINS-1:0]   PIN_ANALOG,
  output logic      [GPP_PINS-1:0]   PIN_IN_LEVEL,
  output logic                       PORT_D_PULLUP_DISABLE,
  output logic                       PORT_E_PULLUP_DISABLE,
  output logic                       PORT_J_PULLUP_DISABLE,
  output gpp_pkg::gpp_od_s           OD_SEL
);
  import gpp_pkg::*;

  logic [GPP_PINS-1:0] lat_ff;
  logic [GPP_PINS-1:0] dir_ff;
  logic [2:0]          pu_ff;
  logic [1:0]          sod_ff;
  logic [2:0]          pod_ff;
  logic [GPP_DW-1:0]   rdata_ff;
  logic [GPP_PINS-1:0] pin_sync;

  gpp_sync #(.W(GPP_PINS)) u_sync (
    .clk (CLK),
    .rst (RST),
    .ce  (CE),
    .d   (PIN_I),
    .q   (pin_sync)
  );

  wire sel_level = (ADDR == GPP_OFS_LEVEL);
  wire sel_latch = (ADDR == GPP_OFS_LATCH);
  wire sel_dir   = (ADDR == GPP_OFS_DIR);
  wire wr_level  = CE && WR && sel_level;
  wire wr_latch  = CE && WR && sel_latch;
  wire wr_dir    = CE && WR && sel_dir;

  // Port J bit is hard-wired off on the small package
  wire pu_j_mask = HAS_PORT_J; // R11

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      lat_ff <= GPP_RST_LAT;
      dir_ff <= GPP_RST_DIR;
      pu_ff  <= GPP_RST_PU; // R8
      sod_ff <= GPP_RST_SODS;
      pod_ff <= GPP_RST_PODS;
    end
    else
    begin
      if (wr_level || wr_latch)
        lat_ff <= WDATA[GPP_PINS-1:0]; // R15
      if (wr_level)
        pu_ff <= WDATA[GPP_BIT_PU_D:GPP_BIT_PU_J]; // R7
      if (wr_latch)
        sod_ff <= WDATA[GPP_BIT_SER2:GPP_BIT_SER1]; // R9
      if (wr_dir)
      begin
        dir_ff <= WDATA[GPP_PINS-1:0]; // R2
        pod_ff <= WDATA[GPP_BIT_SPI:GPP_BIT_CC1]; // R9
      end
    end
  end

  // Read mux: stored values and synchronised pin levels, never pin overrides
  logic [GPP_DW-1:0] rd_mux;
  wire  [2:0]        pu_rd = {pu_ff[2:1], pu_ff[0] & pu_j_mask}; // R11
  always_comb
  begin
    rd_mux = GPP_ZERO_BYTE;
    if (sel_level)
      rd_mux = {pu_rd, pin_sync}; // R15
    else if (sel_latch)
      rd_mux = {sod_ff, 1'b0, lat_ff}; // R10
    else if (sel_dir)
      rd_mux = {pod_ff, dir_ff}; // R6
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      rdata_ff <= GPP_ZERO_BYTE;
    else if (CE)
      rdata_ff <= RD ? rd_mux : GPP_ZERO_BYTE;
  end
  assign RDATA = rdata_ff;

  // Pin drive resolution, lowest priority first
  logic [GPP_PINS-1:0] drv_o;
  logic [GPP_PINS-1:0] drv_oe_n;
  logic [GPP_PINS-1:0] ana;
  always_comb
  begin
    drv_o    = lat_ff;
    drv_oe_n = dir_ff; // R1 R2
    ana      = '0;
    // Serial 2 outputs beat the latch; direction bit does not matter
    if (PERIPH.ser2_tx_en)
    begin
      drv_o[GPP_PIN_TX] = PERIPH.ser2_tx; // R12
      // Open-drain: release the pin instead of driving high
      drv_oe_n[GPP_PIN_TX] = PERIPH.ser2_active && sod_ff[1] && PERIPH.ser2_tx; // R3
    end
    if (PERIPH.ser2_dt_en)
    begin
      drv_o[GPP_PIN_DT]    = PERIPH.ser2_dt; // R12
      drv_oe_n[GPP_PIN_DT] = 1'b0;
    end
    if (PERIPH.rtc_en)
    begin
      drv_o[GPP_PIN_SEG]    = PERIPH.rtc; // R14
      drv_oe_n[GPP_PIN_SEG] = 1'b0;
    end
    if (PERIPH.lcd_segment_26_drive_en)
    begin
      drv_o[GPP_PIN_SEG]    = PERIPH.lcd_segment_26_drive; // R4
      drv_oe_n[GPP_PIN_SEG] = 1'b1;
      ana[GPP_PIN_SEG]      = 1'b1;
    end
    if (PERIPH.lcd_pump_en)
    begin
      drv_o[GPP_PIN_DT]      = 1'b0; // R5
      drv_oe_n[GPP_PIN_DT]   = 1'b1;
      ana[GPP_PIN_DT]        = 1'b1;
      drv_o[GPP_PIN_CAPB]    = 1'b0;
      drv_oe_n[GPP_PIN_CAPB] = 1'b1;
      ana[GPP_PIN_CAPB]      = 1'b1;
    end
    if (PERIPH.lcd_bias_en)
    begin
      drv_o[GPP_PIN_BIAS]    = 1'b0; // R5
      drv_oe_n[GPP_PIN_BIAS] = 1'b1;
      ana[GPP_PIN_BIAS]      = 1'b1;
    end
  end

  // Pin-level samples are blanked on analog pins so peripherals see nothing
  assign PIN_O        = drv_o;
  assign PIN_OE_N     = drv_oe_n;
  assign PIN_ANALOG   = ana;
  assign PIN_IN_LEVEL = pin_sync & ~ana; // R5 R13

  assign PORT_D_PULLUP_DISABLE = pu_ff[2]; // R7
  assign PORT_E_PULLUP_DISABLE = pu_ff[1];
  assign PORT_J_PULLUP_DISABLE = pu_ff[0] | ~pu_j_mask; // R11

  // One assignment drives the whole struct so no member has a second driver
  assign OD_SEL = '{
    serial2_open_drain_sel:  sod_ff[1], // R9
    serial1_open_drain_sel:  sod_ff[0],
    spi_open_drain_sel:      pod_ff[2],
    capcomp2_open_drain_sel: pod_ff[1],
    capcomp1_open_drain_sel: pod_ff[0]
  };

  // Assertions
  AST_SEG_OVERRIDE: assert property (@(posedge CLK) disable iff (RST) // R4
    PERIPH.lcd_segment_26_drive_en |-> PIN_OE_N[GPP_PIN_SEG] && PIN_ANALOG[GPP_PIN_SEG])
    else $error("segment drive did not own pin 4");
  AST_PUMP_ISOLATE: assert property (@(posedge CLK) disable iff (RST) // R5
    PERIPH.lcd_pump_en |-> PIN_OE_N[GPP_PIN_DT] && PIN_OE_N[GPP_PIN_CAPB] &&
      !PIN_IN_LEVEL[GPP_PIN_DT])
    else $error("charge pump pins not isolated");
  AST_BIAS_ISOLATE: assert property (@(posedge CLK) disable iff (RST) // R5
    PERIPH.lcd_bias_en |-> PIN_OE_N[GPP_PIN_BIAS] && !PIN_IN_LEVEL[GPP_PIN_BIAS])
    else $error("bias pin not isolated");
  AST_DIR_READ: assert property (@(posedge CLK) disable iff (RST || !CE) // R6
    RD && sel_dir |=> RDATA[GPP_PINS-1:0] == $past(dir_ff))
    else $error("direction read differs from stored value");
  AST_PU_WRITE: assert property (@(posedge CLK) disable iff (RST) // R7
    wr_level |=> pu_ff == $past(WDATA[GPP_BIT_PU_D:GPP_BIT_PU_J]))
    else $error("pull-up bits not loaded");
  AST_PU_RESET: assert property (@(posedge CLK) // R8
    RST |=> PORT_D_PULLUP_DISABLE && PORT_E_PULLUP_DISABLE && PORT_J_PULLUP_DISABLE)
    else $error("pull-ups enabled after reset");
  AST_LAT5_ZERO: assert property (@(posedge CLK) disable iff (RST || !CE) // R10
    RD && sel_latch |=> RDATA[5] == 1'b0)
    else $error("latch bit 5 read as one");
  AST_TX_PRIO: assert property (@(posedge CLK) disable iff (RST) // R12
    PERIPH.ser2_tx_en && !PERIPH.lcd_pump_en |-> PIN_O[GPP_PIN_TX] == PERIPH.ser2_tx)
    else $error("transmit lost to latch");
  AST_RTC_OUT: assert property (@(posedge CLK) disable iff (RST) // R14
    PERIPH.rtc_en && !PERIPH.lcd_segment_26_drive_en |->
      !PIN_OE_N[GPP_PIN_SEG] && PIN_O[GPP_PIN_SEG] == PERIPH.rtc)
    else $error("clock output not on pin 4");
  AST_LAT_DRIVE: assert property (@(posedge CLK) disable iff (RST) // R2
    wr_latch && WDATA[GPP_PIN_BIAS] && !PERIPH.lcd_bias_en && !dir_ff[GPP_PIN_BIAS] && !$past(RST)
      |=> PIN_O[GPP_PIN_BIAS] || PERIPH.lcd_bias_en)
    else $error("latch not driven onto pin 0");
  AST_PORTJ_SMALL: assert property (@(posedge CLK) disable iff (RST || !CE) // R11
    !HAS_PORT_J && RD && sel_level |=> RDATA[GPP_BIT_PU_J] == 1'b0)
    else $error("port J pull-up bit read on small package");

  // Serial 2 takes pin 1 and pin 2 away from the latch
  AST_TX_RELEASE: assert property (@(posedge CLK) disable iff (RST) // R3
    PERIPH.ser2_tx_en && PERIPH.ser2_active && sod_ff[1] |->
      PIN_OE_N[GPP_PIN_TX] == PERIPH.ser2_tx)
    else $error("open-drain transmit did not release pin 1");
  AST_TX_PUSH: assert property (@(posedge CLK) disable iff (RST) // R12
    PERIPH.ser2_tx_en && !(PERIPH.ser2_active && sod_ff[1]) |-> !PIN_OE_N[GPP_PIN_TX])
    else $error("transmit did not drive pin 1");
  AST_DT_PRIO: assert property (@(posedge CLK) disable iff (RST) // R12
    PERIPH.ser2_dt_en && !PERIPH.lcd_pump_en |->
      !PIN_OE_N[GPP_PIN_DT] && PIN_O[GPP_PIN_DT] == PERIPH.ser2_dt)
    else $error("sync data lost to latch");

  // With no function on a pin, direction and latch own it; a slip shows as a stuck pad
  AST_PIN0_PLAIN: assert property (@(posedge CLK) disable iff (RST) // R5
    !PERIPH.lcd_bias_en |-> !PIN_ANALOG[GPP_PIN_BIAS] &&
      PIN_OE_N[GPP_PIN_BIAS] == dir_ff[GPP_PIN_BIAS] &&
      PIN_O[GPP_PIN_BIAS] == lat_ff[GPP_PIN_BIAS])
    else $error("pin 0 does not follow direction and latch");
  AST_PIN1_PLAIN: assert property (@(posedge CLK) disable iff (RST) // R2
    !PERIPH.ser2_tx_en |-> PIN_OE_N[GPP_PIN_TX] == dir_ff[GPP_PIN_TX] &&
      PIN_O[GPP_PIN_TX] == lat_ff[GPP_PIN_TX])
    else $error("pin 1 does not follow direction and latch");
  AST_PIN3_PLAIN: assert property (@(posedge CLK) disable iff (RST) // R1
    !PERIPH.lcd_pump_en |-> !PIN_ANALOG[GPP_PIN_CAPB] &&
      PIN_OE_N[GPP_PIN_CAPB] == dir_ff[GPP_PIN_CAPB] &&
      PIN_O[GPP_PIN_CAPB] == lat_ff[GPP_PIN_CAPB])
    else $error("pin 3 does not follow direction and latch");
  AST_SEG_RELEASED: assert property (@(posedge CLK) disable iff (RST) // R4
    !PERIPH.lcd_segment_26_drive_en && !PERIPH.rtc_en |-> !PIN_ANALOG[GPP_PIN_SEG] &&
      PIN_OE_N[GPP_PIN_SEG] == dir_ff[GPP_PIN_SEG] &&
      PIN_O[GPP_PIN_SEG] == lat_ff[GPP_PIN_SEG])
    else $error("pin 4 not back to port use with segment off");

  // Register writes land in the addressed fields
  AST_LEVEL_LATCH: assert property (@(posedge CLK) disable iff (RST) // R15
    wr_level |=> lat_ff == $past(WDATA[GPP_PINS-1:0]))
    else $error("data register write missed the latch");
  AST_PERIPH_OD: assert property (@(posedge CLK) disable iff (RST) // R9
    wr_dir |=> OD_SEL.spi_open_drain_sel == $past(WDATA[GPP_BIT_SPI]) &&
      OD_SEL.capcomp2_open_drain_sel == $past(WDATA[GPP_BIT_CC2]) &&
      OD_SEL.capcomp1_open_drain_sel == $past(WDATA[GPP_BIT_CC1]))
    else $error("peripheral open-drain selects not loaded");
  AST_SERIAL_OD: assert property (@(posedge CLK) disable iff (RST) // R9
    wr_latch |=> OD_SEL.serial2_open_drain_sel == $past(WDATA[GPP_BIT_SER2]) &&
      OD_SEL.serial1_open_drain_sel == $past(WDATA[GPP_BIT_SER1]))
    else $error("serial open-drain selects not loaded");

  // Peripheral overrides never reach the stored bits, so read-modify-write stays safe
  AST_DIR_HOLD: assert property (@(posedge CLK) disable iff (RST) // R6
    !wr_dir |=> $stable(dir_ff))
    else $error("direction bits moved without a write");
  AST_LAT_HOLD: assert property (@(posedge CLK) disable iff (RST) // R15
    !wr_level && !wr_latch |=> $stable(lat_ff))
    else $error("latch bits moved without a write");
  AST_PU_HOLD: assert property (@(posedge CLK) disable iff (RST) // R7
    !wr_level |=> $stable(pu_ff))
    else $error("pull-up bits moved without a write");
  AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (RST) // R2
    !CE |=> $stable(lat_ff) && $stable(dir_ff) && $stable(pu_ff) &&
      $stable(sod_ff) && $stable(pod_ff) && $stable(pin_sync) && $stable(RDATA))
    else $error("state moved while clock enable low");

  // Read paths return sampled pins and stored latch bits
  AST_LEVEL_READ: assert property (@(posedge CLK) disable iff (RST || !CE) // R15
    RD && sel_level |=> RDATA[GPP_PINS-1:0] == $past(pin_sync))
    else $error("data register read differs from pin levels");
  AST_LATCH_READ: assert property (@(posedge CLK) disable iff (RST || !CE) // R2
    RD && sel_latch |=> RDATA[GPP_PINS-1:0] == $past(lat_ff))
    else $error("latch read differs from stored value");
  AST_J_SMALL_OFF: assert property (@(posedge CLK) disable iff (RST) // R11
    !HAS_PORT_J |-> PORT_J_PULLUP_DISABLE)
    else $error("port J pull-ups enabled on small package");

  COV_OD_TX: cover property (@(posedge CLK) PERIPH.ser2_active && sod_ff[1] && PERIPH.ser2_tx_en);
  COV_SEG: cover property (@(posedge CLK) PERIPH.lcd_segment_26_drive_en && !dir_ff[GPP_PIN_SEG]);
  COV_WR_RD: cover property (@(posedge CLK) wr_level ##1 RD && sel_level);
  COV_PUMP_DT: cover property (@(posedge CLK) PERIPH.lcd_pump_en && PERIPH.ser2_dt_en);
  COV_RTC_IN: cover property (@(posedge CLK) PERIPH.rtc_en && dir_ff[GPP_PIN_SEG]);
endmodule // gpp_port

// ### gpp_ext_model.sv
// Board-side model of the five pads, with a pull-up resistor on each pad
`timescale 1ns/1ps
module gpp_ext_model (
  input  wire logic [gpp_pkg::GPP_PINS-1:0] pin_o,
  input  wire logic [gpp_pkg::GPP_PINS-1:0] pin_oe_n,
  input  wire logic [gpp_pkg::GPP_PINS-1:0] drv_en,
  input  wire logic [gpp_pkg::GPP_PINS-1:0] drv_val,
  output logic      [gpp_pkg::GPP_PINS-1:0] pad
);
  import gpp_pkg::*;
  // A released pad takes the board drive when enabled, else the pull-up level, never a stale driven value
  always_comb
  begin
    for (int i = 0; i < GPP_PINS; i++)
    begin
      pad[i] = !pin_oe_n[i] ? pin_o[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule // gpp_ext_model

// ### tb_five_pin_io_port_with_pullup_ctrl.sv
// Self-checking bench for the five-pin port: registers, pins and overrides
`timescale 1ns/1ps
module tb_five_pin_io_port_with_pullup_ctrl;
  import gpp_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        ce      = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [1:0]  addr    = 2'h0;
  logic [7:0]  wdata   = 8'h00;
  logic [4:0]  drv_en  = 5'h00;
  logic [4:0]  drv_val = 5'h00;
  gpp_periph_s per     = '0;
  logic [7:0]  rdata, rdata_j;
  logic [4:0]  pad, pin_o, oe_n, analog, in_lvl;
  logic        pud, pue, puj, puj_j;
  gpp_od_s     od;
  int          err_count   = 0;
  int          checks_done = 0;

  always #2 clk = ~clk;

  gpp_port dut (
    .CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PERIPH(per), .PIN_I(pad), .PIN_O(pin_o), .PIN_OE_N(oe_n),
    .PIN_ANALOG(analog), .PIN_IN_LEVEL(in_lvl), .PORT_D_PULLUP_DISABLE(pud),
    .PORT_E_PULLUP_DISABLE(pue), .PORT_J_PULLUP_DISABLE(puj), .OD_SEL(od)
  );
  // Small package variant shares every input with the main instance
  gpp_port #(.HAS_PORT_J(1'b0)) dut_small (
    .CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata_j), .PERIPH(per), .PIN_I(pad), .PIN_O(), .PIN_OE_N(),
    .PIN_ANALOG(), .PIN_IN_LEVEL(), .PORT_D_PULLUP_DISABLE(),
    .PORT_E_PULLUP_DISABLE(), .PORT_J_PULLUP_DISABLE(puj_j), .OD_SEL()
  );
  gpp_ext_model board (
    .pin_o(pin_o), .pin_oe_n(oe_n), .drv_en(drv_en), .drv_val(drv_val), .pad(pad)
  );

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, exp);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Pin synchroniser needs a few edges before levels are readable
    repeat (3) @(posedge clk);
    reg_rd(GPP_OFS_LEVEL, 8'hFF);
    chk("rdata_small", rdata_j, 8'hDF);
    reg_rd(GPP_OFS_LATCH, 8'h00);
    reg_rd(GPP_OFS_DIR, 8'h1F);
    chk("oe_n", {3'h0, oe_n}, 8'h1F);
    chk("pullup", {5'h00, pud, pue, puj}, 8'h07);
    chk("od_sel", {3'h0, od}, 8'h00);
    $display("test reset done");
    reg_wr(GPP_OFS_DIR, 8'hE0);
    reg_wr(GPP_OFS_LATCH, 8'hF5);
    reg_rd(GPP_OFS_LATCH, 8'hD5);
    reg_rd(GPP_OFS_DIR, 8'hE0);
    chk("od_sel", {3'h0, od}, 8'h1F);
    chk("pin_o", {3'h0, pin_o}, 8'h15);
    chk("oe_n", {3'h0, oe_n}, 8'h00);
    reg_wr(GPP_OFS_LEVEL, 8'h0A);
    reg_rd(GPP_OFS_LATCH, 8'hCA);
    chk("pullup", {5'h00, pud, pue, puj}, 8'h00);
    chk("pullup_small", {7'h00, puj_j}, 8'h01);
    repeat (3) @(posedge clk);
    reg_rd(GPP_OFS_LEVEL, 8'h0A);
    $display("test registers done");
    reg_wr(GPP_OFS_DIR, 8'h1F);
    drv_en  <= 5'h1F;
    drv_val <= 5'h13;
    repeat (3) @(posedge clk);
    reg_rd(GPP_OFS_LEVEL, 8'h13);
    chk("in_level", {3'h0, in_lvl}, 8'h13);
    @(posedge clk);
    drv_en <= 5'h00;
    $display("test inputs done");
    // Serial 2 open-drain is set, so a transmit 1 releases pin 1
    per <= '{ser2_active: 1'b1, ser2_tx_en: 1'b1, ser2_tx: 1'b1, ser2_dt_en: 1'b1,
             ser2_dt: 1'b1, rtc_en: 1'b1, rtc: 1'b1, default: 1'b0};
    @(negedge clk);
    chk("oe_n", {3'h0, oe_n}, 8'h0B);
    chk("pin_o_4_2", {6'h00, pin_o[4], pin_o[2]}, 8'h03);
    @(posedge clk);
    per.ser2_tx <= 1'b0;
    @(negedge clk);
    chk("oe_n", {3'h0, oe_n}, 8'h09);
    chk("pin_o_1", {7'h00, pin_o[1]}, 8'h00);
    reg_rd(GPP_OFS_DIR, 8'h1F);
    @(posedge clk);
    per.lcd_segment_26_drive_en    <= 1'b1;
    per.lcd_pump_en <= 1'b1;
    per.lcd_bias_en <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("analog", {3'h0, analog}, 8'h1D);
    chk("oe_n", {3'h0, oe_n}, 8'h1D);
    chk("in_level", {3'h0, in_lvl}, 8'h00);
    @(posedge clk);
    per <= '0;
    $display("test overrides done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pullup", {5'h00, pud, pue, puj}, 8'h07);
    reg_wr(2'h3, 8'hFF);
    reg_rd(2'h3, 8'h00);
    reg_rd(GPP_OFS_DIR, 8'h1F);
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(GPP_OFS_DIR, 8'h00);
    ce <= 1'b1;
    reg_rd(GPP_OFS_DIR, 8'h1F);
    $display("test reset and refusals done");
    wrap_up();
  end

  // About 60 cycles of traffic; the limit leaves ample margin
  initial
  begin
    #(4 * 2000);
    err_count++;
    wrap_up();
  end
endmodule // tb_five_pin_io_port_with_pullup_ctrl
